// ==== rtl/dcvchk_top.sv ====
// dynamic core voltage window check driven by the identification code
// Contract
// - dynamic check runs apart from and in addition to the static check
// - four regulator modes over three specifications steer code decoding
// - legacy mode assumes code changes at most once per 5 us
// - skew glitches on identification lines are ignored and not averaged
// - identification voltage is averaged over a 1.5 ms window
// - dynamic comparison uses the window average, not the current code
// - upper limit is average plus offset, lower is average minus offset
// - error when core voltage is above upper or below lower limit
// - dynamic and static comparisons run once every 100 ms
// - an off code anywhere in the window skips that dynamic check
// - upper check disabled when average plus offset exceeds 1.5875 V
// - seventh line is a general input in legacy mode, else bit six
`timescale 1ns/100ps
module dcvchk_top #(
    parameter int PERIOD = dcvchk_pkg::PERIOD_CYC,
    parameter int WINDOW = dcvchk_pkg::WINDOW_CYC
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // identification pins from the processor
    input wire logic [dcvchk_pkg::VID_W-1:0] voltage_id_inputs,
    // measured core voltage and static limits, millivolts
    input wire logic [dcvchk_pkg::MV_W-1:0] core_voltage_input,
    input wire logic [dcvchk_pkg::MV_W-1:0] static_high_mv,
    input wire logic [dcvchk_pkg::MV_W-1:0] static_low_mv,
    // software configuration
    input wire logic [1:0] regulator_mode,
    input wire logic [dcvchk_pkg::MV_W-1:0] upper_offset_mv,
    input wire logic [dcvchk_pkg::MV_W-1:0] lower_offset_mv,
    input wire logic dyn_err_clear,
    input wire logic static_err_clear,
    // status
    output logic dyn_err_ff,
    output logic dyn_err_event_ff,
    output logic static_err_ff,
    output logic check_done_ff,
    output logic check_skipped_ff,
    output logic upper_disabled_ff,
    output logic voltage_id_bit_six_ff,
    output logic [dcvchk_pkg::MV_W-1:0] avg_mv_ff
);
    initial begin
        if (WINDOW < 2 || WINDOW >= PERIOD) $error("window must be shorter than the period");
    end

    localparam int PW = $clog2(PERIOD + 1);
    localparam int SW = dcvchk_pkg::MV_W + $clog2(WINDOW + 1);

    // three-stage synchroniser for the identification pins
    logic [dcvchk_pkg::VID_W-1:0] sync1_ff, sync2_ff, sync3_ff;
    logic [dcvchk_pkg::VID_W-1:0] vid_ff;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
            vid_ff <= '0;
        end else if (clk_en) begin
            sync1_ff <= voltage_id_inputs;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff) begin
                vid_ff <= sync3_ff;
            end
        end
    end

    // decode with skew filter
    logic stable, code_off;
    logic [dcvchk_pkg::MV_W-1:0] target_mv;
    dcvchk_vid_decode u_dec (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .vid_sync(vid_ff),
        .mode(regulator_mode),
        .stable_ff(stable),
        .off_ff(code_off),
        .target_mv_ff(target_mv)
    );

    // scheduler: the window sits at the end of each period
    typedef enum logic [1:0] {DCVCHK_IDLE, DCVCHK_SAMPLE, DCVCHK_DIVIDE, DCVCHK_COMPARE} dcvchk_state_t;
    dcvchk_state_t state_ff, nxt_state;
    logic [PW-1:0] tick_ff;
    logic [SW-1:0] sum_ff;
    logic [SW-1:0] quot_ff;
    logic [SW-1:0] rem_ff;
    logic off_seen_ff;
    logic [dcvchk_pkg::MV_W-1:0] hold_mv_ff;

    wire period_end = (tick_ff == PW'(PERIOD - 1));
    wire win_start = (tick_ff == PW'(PERIOD - WINDOW - 1));
    wire div_done = (rem_ff < SW'(WINDOW));
    // value taken this sample; the last window sample must reach the divider too
    wire [dcvchk_pkg::MV_W-1:0] sample_mv = stable ? target_mv : hold_mv_ff;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            DCVCHK_IDLE: if (win_start) nxt_state = DCVCHK_SAMPLE;
            DCVCHK_SAMPLE: if (period_end) nxt_state = DCVCHK_DIVIDE;
            DCVCHK_DIVIDE: if (div_done) nxt_state = DCVCHK_COMPARE;
            DCVCHK_COMPARE: nxt_state = DCVCHK_IDLE;
        endcase
    end

    // period counter and window accumulation; glitch codes never enter the sum
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff <= DCVCHK_IDLE;
            tick_ff <= '0;
            sum_ff <= '0;
            quot_ff <= '0;
            rem_ff <= '0;
            off_seen_ff <= 1'b0;
            hold_mv_ff <= '0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            tick_ff <= period_end ? '0 : tick_ff + PW'(1);
            if (state_ff == DCVCHK_IDLE && win_start) begin
                sum_ff <= '0;
                off_seen_ff <= code_off;
                hold_mv_ff <= target_mv;
            end else if (state_ff == DCVCHK_SAMPLE) begin
                // last settled value is used while a new code is still settling
                sum_ff <= sum_ff + SW'(sample_mv);
                if (stable) hold_mv_ff <= target_mv;
                if (code_off) off_seen_ff <= 1'b1;
                if (period_end) begin
                    quot_ff <= '0;
                    rem_ff <= sum_ff + SW'(sample_mv);
                end
            end else if (state_ff == DCVCHK_DIVIDE && !div_done) begin
                // plain division by repeated subtraction, a few thousand cycles at most
                rem_ff <= rem_ff - SW'(WINDOW);
                quot_ff <= quot_ff + SW'(1);
            end
        end
    end

    // limits built from the average
    wire [dcvchk_pkg::MV_W-1:0] avg_mv = quot_ff[dcvchk_pkg::MV_W-1:0];
    wire [dcvchk_pkg::MV_W:0] upper_sum = {1'b0, avg_mv} + {1'b0, upper_offset_mv};
    wire [dcvchk_pkg::MV_W:0] lower_lim = {1'b0, avg_mv} - {1'b0, lower_offset_mv};
    wire upper_off = (upper_sum > {1'b0, dcvchk_pkg::UPPER_CEIL_MV});
    wire above = !upper_off && ({1'b0, core_voltage_input} > upper_sum);
    wire below = !lower_lim[dcvchk_pkg::MV_W] && (core_voltage_input < lower_lim[dcvchk_pkg::MV_W-1:0]);
    wire compare = (state_ff == DCVCHK_COMPARE) && clk_en;
    wire dyn_hit = compare && !off_seen_ff && (above || below);
    wire static_hit = compare && ((core_voltage_input > static_high_mv) || (core_voltage_input < static_low_mv));

    // status flags: a new hit wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dyn_err_ff <= dcvchk_pkg::ERR_RESET;
            dyn_err_event_ff <= 1'b0;
            static_err_ff <= dcvchk_pkg::ERR_RESET;
            check_done_ff <= 1'b0;
            check_skipped_ff <= 1'b0;
            upper_disabled_ff <= 1'b0;
            voltage_id_bit_six_ff <= 1'b0;
            avg_mv_ff <= '0;
        end else if (clk_en) begin
            dyn_err_ff <= dyn_hit | (dyn_err_ff & ~dyn_err_clear);
            dyn_err_event_ff <= dyn_hit;
            static_err_ff <= static_hit | (static_err_ff & ~static_err_clear);
            check_done_ff <= compare;
            // general input level reported only in legacy mode
            voltage_id_bit_six_ff <= (regulator_mode == dcvchk_pkg::DCVCHK_MODE_LEGACY) ? vid_ff[6] : 1'b0;
            if (compare) begin
                check_skipped_ff <= off_seen_ff;
                upper_disabled_ff <= upper_off;
                avg_mv_ff <= avg_mv;
            end
        end
    end
endmodule : dcvchk_top

// ==== rtl/dcvchk_pkg.sv ====
// constants, types and timing for the dynamic core voltage check
package dcvchk_pkg;
    localparam int CLK_MHZ = 200;
    localparam int CLK_HZ = 200000000;
    // timing figures in their own units
    localparam int WINDOW_US_X10 = 15000;
    localparam int PERIOD_MS = 100;
    localparam int STEP_NS = 5000;
    localparam int WINDOW_CYC = (WINDOW_US_X10 * CLK_MHZ) / 10;
    localparam int PERIOD_CYC = (PERIOD_MS * CLK_MHZ) * 1000;
    localparam int STEP_CYC = (STEP_NS * CLK_MHZ) / 1000;
    // skew filter: a code must hold this long before it counts
    localparam int SETTLE_NS = 400;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ) / 1000;
    // voltages are held in millivolts, 12 bits
    localparam int MV_W = 12;
    localparam logic [MV_W-1:0] UPPER_CEIL_MV = 12'h633; // 1587.5 mv rounded down to 1587
    localparam logic [MV_W-1:0] LSB_LEGACY_MV = 12'h00d; // 12.5 mv steps, rounded
    localparam logic [MV_W-1:0] LSB_NEW_MV = 12'h006;    // 6.25 mv steps, rounded
    localparam logic [MV_W-1:0] BASE_LEGACY_MV = 12'h640;
    localparam logic [MV_W-1:0] BASE_NEW_MV = 12'h640;
    localparam int VID_W = 7;
    localparam int ERR_BIT_POS = 0;
    localparam logic ERR_RESET = 1'b0;
    // regulator modes
    typedef enum logic [1:0] {
        DCVCHK_MODE_LEGACY = 2'h0,
        DCVCHK_MODE_LEGACY_EXT = 2'h1,
        DCVCHK_MODE_NEW = 2'h2,
        DCVCHK_MODE_NEW_ALT = 2'h3
    } dcvchk_mode_t;
endpackage : dcvchk_pkg

// ==== rtl/dcvchk_vid_decode.sv ====
// identification code to target voltage decode with skew filtering
`timescale 1ns/100ps
module dcvchk_vid_decode #(
    parameter int SETTLE = dcvchk_pkg::SETTLE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // synchronised code and mode
    input wire logic [dcvchk_pkg::VID_W-1:0] vid_sync,
    input wire logic [1:0] mode,
    // settled code output
    output logic stable_ff,
    output logic off_ff,
    output logic [dcvchk_pkg::MV_W-1:0] target_mv_ff
);
    initial begin
        if (SETTLE < 1 || SETTLE > 1000) $error("settle count out of range");
    end

    logic [dcvchk_pkg::VID_W-1:0] last_ff;
    logic [9:0] hold_ff;
    wire legacy = (mode == dcvchk_pkg::DCVCHK_MODE_LEGACY);
    wire legacy_ext = (mode == dcvchk_pkg::DCVCHK_MODE_LEGACY_EXT);
    // legacy mode uses six bits; the seventh line is a general input there
    wire [dcvchk_pkg::VID_W-1:0] code = legacy ? {1'b0, vid_sync[5:0]} : vid_sync;
    wire [dcvchk_pkg::MV_W-1:0] code_w = {5'h00, code};
    wire [dcvchk_pkg::MV_W-1:0] lsb = (legacy || legacy_ext) ? dcvchk_pkg::LSB_LEGACY_MV : dcvchk_pkg::LSB_NEW_MV;
    wire [dcvchk_pkg::MV_W-1:0] base = (legacy || legacy_ext) ? dcvchk_pkg::BASE_LEGACY_MV : dcvchk_pkg::BASE_NEW_MV;
    wire [23:0] step_mv = code_w * lsb;
    wire code_off = (legacy || legacy_ext) ? (code[5:0] == 6'h3e || code[5:0] == 6'h3f) : (code == 7'h00);
    wire [dcvchk_pkg::MV_W-1:0] mv = (step_mv[11:0] > base) ? 12'h000 : base - step_mv[11:0];
    wire settled = (hold_ff == 10'(SETTLE - 1));

    // a code counts only once it has held for the settle time
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            last_ff <= '0;
            hold_ff <= '0;
            stable_ff <= 1'b0;
            off_ff <= 1'b0;
            target_mv_ff <= '0;
        end else if (clk_en) begin
            last_ff <= code;
            // settle time stays far below the 5 us minimum spacing of code changes
            hold_ff <= (code != last_ff) ? 10'h000 : (settled ? hold_ff : hold_ff + 10'h001);
            stable_ff <= settled && (code == last_ff);
            if (settled && (code == last_ff)) begin
                off_ff <= code_off;
                target_mv_ff <= code_off ? 12'h000 : mv;
            end
        end
    end
endmodule : dcvchk_vid_decode

// ==== tb/dcvchk_assertions.sv ====
// concurrent checks on the ports of the dynamic core voltage window check
`timescale 1ns/100ps
module dcvchk_assertions (
    // clock, reset and inputs
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [11:0] core_voltage_input,
    input wire logic [1:0] regulator_mode,
    input wire logic [11:0] upper_offset_mv,
    input wire logic [11:0] lower_offset_mv,
    input wire logic dyn_err_clear,
    input wire logic static_err_clear,
    // status
    input wire logic dyn_err_ff,
    input wire logic dyn_err_event_ff,
    input wire logic static_err_ff,
    input wire logic check_done_ff,
    input wire logic check_skipped_ff,
    input wire logic upper_disabled_ff,
    input wire logic voltage_id_bit_six_ff,
    input wire logic [11:0] avg_mv_ff
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // sums widened so the limits never wrap
    wire [12:0] hi_lim = {1'b0, avg_mv_ff} + {1'b0, upper_offset_mv};
    wire [12:0] lo_sum = {1'b0, core_voltage_input} + {1'b0, lower_offset_mv};
    AST_EVENT_ON_DONE: assert property (dyn_err_event_ff |-> check_done_ff)
        else $error("error event outside a check");
    AST_EVENT_LATCHES: assert property (dyn_err_event_ff |-> dyn_err_ff)
        else $error("error event not latched");
    AST_STICKY_HOLDS: assert property (dyn_err_ff && !dyn_err_clear && clk_en |=> dyn_err_ff)
        else $error("dynamic error dropped");
    AST_STATIC_HOLDS: assert property (static_err_ff && !static_err_clear && clk_en |=> static_err_ff)
        else $error("static error dropped");
    AST_DONE_SPACED: assert property (check_done_ff |=> !check_done_ff [*8])
        else $error("checks too close");
    AST_SKIP_QUIET: assert property (check_done_ff && check_skipped_ff |-> !dyn_err_event_ff)
        else $error("error on skipped check");
    AST_ABOVE_FIRES: assert property (check_done_ff && !check_skipped_ff && !upper_disabled_ff &&
        {1'b0, core_voltage_input} > hi_lim |-> dyn_err_event_ff) else $error("high miss");
    AST_CEIL_FLAG: assert property (check_done_ff && !check_skipped_ff |->
        upper_disabled_ff == (hi_lim > 13'h0633)) else $error("ceiling flag wrong");
    AST_CEIL_LOW_ONLY: assert property (dyn_err_event_ff && upper_disabled_ff |->
        lo_sum < {1'b0, avg_mv_ff}) else $error("upper check not disabled");
    AST_BIT_SIX_OFF: assert property ((regulator_mode != 2'h0) [*4] |-> !voltage_id_bit_six_ff)
        else $error("bit six shown outside legacy");
    // main scenarios
    cover property (check_done_ff && dyn_err_event_ff);
    cover property (check_done_ff && check_skipped_ff);
    cover property (check_done_ff && upper_disabled_ff);
endmodule : dcvchk_assertions

// ==== tb/dcvchk_vid_model.sv ====
// processor identification source: one lsb steps, bursts, line skew
`timescale 1ns/100ps
module dcvchk_vid_model #(parameter int STEP = 10) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // wanted code and skew injection
    input wire logic [6:0] goal,
    input wire logic skew,
    // identification pins
    output logic [6:0] vid = 7'h00
);
    logic [6:0] cur = 7'h00;
    int t = 0;
    int run = 0;
    // walk toward goal, resting after 20 steps; skew shows a mixed code briefly
    always @(posedge mclk) begin
        t <= t + 1;
        vid <= cur;
        if (!rst_n) cur <= goal;
        else if (t % STEP == 0 && cur != goal && run < 20) begin
            vid <= cur | (cur > goal ? cur - 7'h01 : cur + 7'h01);
            cur <= cur > goal ? cur - 7'h01 : cur + 7'h01;
            run <= run + 1;
        end else if (t % (5 * STEP) == 0) run <= 0;
        else if (skew && t % 97 == 0) vid <= cur ^ 7'h15;
    end
endmodule : dcvchk_vid_model

// ==== tb/tb_top.sv ====
// self-checking bench for the dynamic core voltage window check
`timescale 1ns/100ps
module tb_top;
    logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, skew = 1'b0;
    logic [6:0] voltage_id_inputs, vid_goal = 7'h00, c;
    logic [11:0] core_voltage_input = 12'h000, static_high_mv = 12'h000, static_low_mv = 12'h000;
    logic [11:0] upper_offset_mv = 12'h000, lower_offset_mv = 12'h000, av, cv, up, lw;
    logic [1:0] regulator_mode = 2'h0, m;
    logic dyn_err_clear = 1'b0, static_err_clear = 1'b0, off, udis, e, se;
    logic dyn_err_ff, dyn_err_event_ff, static_err_ff, check_done_ff, check_skipped_ff;
    logic upper_disabled_ff, voltage_id_bit_six_ff;
    logic [11:0] avg_mv_ff;
    int n_mismatch = 0, checks_done = 0;
    always #2.5 mclk = ~mclk;
    dcvchk_top #(.PERIOD(2000), .WINDOW(100)) dut (.*);
    dcvchk_vid_model #(.STEP(10)) vid_src (.mclk(mclk), .rst_n(rst_n), .goal(vid_goal), .skew(skew),
        .vid(voltage_id_inputs));
    // compare and count
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        checks_done++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    // bounded wait for the next comparison pulse
    task automatic wait_done;
        int i = 0;
        do begin
            @(posedge mclk);
            #1;
            i++;
        end while (check_done_ff !== 1'b1 && i < 9000);
        if (check_done_ff !== 1'b1) n_mismatch++;
    endtask : wait_done
    // target millivolts of a code in a mode
    function automatic logic [11:0] exp_mv(input logic [1:0] md, input logic [6:0] cd);
        if (md == 2'h0) return 12'h640 - 12'h00d * cd[5:0];
        return md == 2'h1 ? 12'h640 - 12'h00d * cd : 12'h640 - 12'h006 * cd;
    endfunction : exp_mv
    // corner cases first, then random codes, modes and levels
    initial begin
        void'($urandom(32'h70b7));
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        for (int k = 0; k < 14; k++) begin
            m = 2'($urandom_range(3));
            c = 7'($urandom_range(127));
            up = 12'($urandom_range(63));
            lw = 12'($urandom_range(63));
            case (k)
                0: begin m = 2'h0; c = 7'h7f; end
                1: begin m = 2'h0; c = 7'h00; end
                2: begin m = 2'h2; c = 7'h00; end
                3: begin m = 2'h3; c = 7'h7f; lw = 12'h400; end
                default: ;
            endcase
            if (m == 2'h1) c[6] = 1'b0;
            av = exp_mv(m, c);
            cv = k == 3 ? 12'h000 : av - 12'h050 + 12'($urandom_range(160));
            off = m < 2'h2 ? c[5:1] == 5'h1f : c == 7'h00;
            udis = {1'b0, av} + {1'b0, up} > 13'h0633;
            e = !off && ((!udis && cv > av + up) || (lw <= av && cv < av - lw));
            @(posedge mclk);
            regulator_mode <= m;
            vid_goal <= c;
            skew <= 1'($urandom_range(1));
            core_voltage_input <= cv;
            upper_offset_mv <= up;
            lower_offset_mv <= lw;
            static_high_mv <= av + 12'($urandom_range(40));
            static_low_mv <= av - 12'($urandom_range(40));
            wait_done();
            se = cv > static_high_mv || cv < static_low_mv;
            @(posedge mclk);
            dyn_err_clear <= 1'b1;
            static_err_clear <= 1'b1;
            @(posedge mclk);
            dyn_err_clear <= 1'b0;
            static_err_clear <= 1'b0;
            wait_done();
            check(dyn_err_event_ff, e);
            check(dyn_err_ff, e);
            check(check_skipped_ff, off);
            check(static_err_ff, se);
            check(voltage_id_bit_six_ff, m == 2'h0 && c[6]);
            if (!off) check(avg_mv_ff, av);
            if (!off) check(upper_disabled_ff, udis);
        end
        report_and_stop();
    end
    // hang guard
    initial begin
        repeat (95000) @(posedge mclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_top
bind dcvchk_top dcvchk_assertions chk (.*);
